// *** inc/instr_subset_pkg.sv ***
// Package for the 4-bit CPU instruction subset executor
// Assumes 10-bit instruction words presented one per machine cycle
package instr_subset_pkg;
    // ------------------------------------------------------------
    // Opcodes (10-bit)
    // ------------------------------------------------------------
    localparam logic [9:0] OPC_NOP      = 10'h000;
    localparam logic [9:0] OPC_POF      = 10'h002;
    localparam logic [9:0] OPC_POF_EN   = 10'h05b;
    localparam logic [9:0] OPC_PORT0    = 10'h220;
    localparam logic [9:0] OPC_PORT1    = 10'h221;
    localparam logic [9:0] OPC_PORT2    = 10'h222;
    localparam logic [9:0] OPC_OR_MEM   = 10'h019;
    localparam logic [9:0] OPC_ROT_R    = 10'h01d;
    localparam logic [9:0] OPC_CY_CLR   = 10'h006;
    localparam logic [9:0] OPC_PD_CLR   = 10'h014;
    localparam logic [9:0] OPC_SUB_RET  = 10'h044;
    localparam logic [9:0] OPC_SKIP_RET = 10'h045;
    localparam logic [9:0] OPC_INT_RET  = 10'h046;
    localparam logic [9:0] OPC_HBR_RST  = 10'h058;
    // Masked groups: load pair 11xxxxyyyy, bank 00010010zz, bit clear 00010011jj
    localparam logic [1:0] GRP_LXY      = 2'h3;
    localparam logic [7:0] GRP_LZ       = 8'h12;
    localparam logic [7:0] GRP_BCLR     = 8'h13;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int PC_W  = 13;
    localparam int SP_W  = 3;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] PD_RST   = 4'hf;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [SP_W-1:0] SP_RST = 3'h7;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [SP_W-1:0] SP_ONE = 3'h1;
endpackage

// *** verilog/instr_subset_exec.sv ***
// Executes a subset of a 4-bit CPU's 10-bit instruction set
// Assumes one instruction word per machine cycle, taken when instr_valid is high and neither busy_r nor backup_r is set
`timescale 1ns/1ns
module instr_subset_exec
    import instr_subset_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // Instruction stream
    input  wire logic            instr_valid,
    input  wire logic [9:0]      instr_word,
    // Data memory at the data pointer
    input  wire logic [3:0]      mem_rd_data,
    output logic                 mem_wr_en,
    output logic [3:0]           mem_wr_data,
    // Interrupt context saved by the interrupt entry logic
    input  wire logic [3:0]      save_x,
    input  wire logic [3:0]      save_y,
    input  wire logic [1:0]      save_z,
    input  wire logic            save_carry,
    input  wire logic            save_skip,
    input  wire logic            save_nop_mode,
    input  wire logic            save_cont_load,
    input  wire logic [3:0]      save_b,
    // Stack push from call logic
    input  wire logic            push_en,
    input  wire logic [PC_W-1:0] push_pc,
    // Architectural state
    output logic [PC_W-1:0]      pc_r,
    output logic [SP_W-1:0]      stack_pointer_r,
    output logic [3:0]           acc_r,
    output logic                 carry_flag_r,
    output logic [3:0]           x_r,
    output logic [3:0]           y_r,
    output logic [1:0]           z_r,
    output logic [3:0]           b_r,
    output logic                 skip_r,
    output logic                 nop_mode_r,
    output logic                 high_bit_ref_enable_flag_r,
    output logic                 busy_r,
    // Ports
    output logic [3:0]           port0_r,
    output logic [3:0]           port1_r,
    output logic [1:0]           port2_r,
    output logic [3:0]           portd_r,
    output logic                 backup_r
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [PC_W-1:0] return_stack [STACK_DEPTH];
    logic            cont_load_r;
    logic            pof_armed_r;
    logic            ret_pend_r;
    logic            ret_skip_r;
    logic            go;
    logic            is_lxy, is_lz, is_bclr;
    logic            is_ret, is_rts, is_rti;
    logic            lxy_skip;
    logic            run;

    assign go      = instr_valid && !busy_r && !backup_r;
    // A skipped return must not pop the stack or restore context
    assign run     = go && !skip_r;
    assign is_lxy  = (instr_word[9:8] == GRP_LXY);
    assign is_lz   = (instr_word[9:2] == GRP_LZ);
    assign is_bclr = (instr_word[9:2] == GRP_BCLR);
    assign is_ret  = (instr_word == OPC_SUB_RET);
    assign is_rts  = (instr_word == OPC_SKIP_RET);
    assign is_rti  = (instr_word == OPC_INT_RET);
    assign lxy_skip = is_lxy && cont_load_r;

    // Two-cycle sequencing for return and return-and-skip (interrupt return takes one); second cycle is busy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r     <= 1'b0;
            ret_pend_r <= 1'b0;
            ret_skip_r <= 1'b0;
        end else begin
            busy_r     <= run && (is_ret || is_rts);
            ret_pend_r <= run && (is_ret || is_rts);
            ret_skip_r <= run && is_rts;
        end
    end

    // Program counter and stack
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r            <= PC_RST;
            stack_pointer_r <= SP_RST;
        end else if (push_en) begin
            stack_pointer_r <= stack_pointer_r + SP_ONE;
        end else if (run && (is_ret || is_rts || is_rti)) begin
            pc_r            <= return_stack[stack_pointer_r];
            stack_pointer_r <= stack_pointer_r - SP_ONE;
        end else if (go) begin
            pc_r            <= pc_r + PC_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push_en) begin
            return_stack[stack_pointer_r + SP_ONE] <= push_pc;
        end
    end

    // Skip flag: set after return-and-skip, consumed by next word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_r <= 1'b0;
        end else if (run && is_rti) begin
            skip_r <= save_skip;
        end else if (ret_pend_r) begin
            skip_r <= ret_skip_r;
        end else if (go) begin
            skip_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pointers and consecutive-load status
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            x_r         <= NIB_ZERO;
            y_r         <= NIB_ZERO;
            z_r         <= 2'h0;
            b_r         <= NIB_ZERO;
            cont_load_r <= 1'b0;
            nop_mode_r  <= 1'b0;
        end else if (run && is_rti) begin
            x_r         <= save_x;
            y_r         <= save_y;
            z_r         <= save_z;
            b_r         <= save_b;
            cont_load_r <= save_cont_load;
            nop_mode_r  <= save_nop_mode;
        end else if (go) begin
            cont_load_r <= is_lxy;
            if (is_lxy && !lxy_skip && !skip_r) begin
                x_r <= instr_word[7:4];
                y_r <= instr_word[3:0];
            end
            if (is_lz && !skip_r) begin
                z_r <= instr_word[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Accumulator, carry and flags
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r                      <= NIB_ZERO;
            carry_flag_r               <= 1'b0;
            high_bit_ref_enable_flag_r <= 1'b0;
        end else if (run && is_rti) begin
            carry_flag_r <= save_carry;
        end else if (go && !skip_r) begin
            case (instr_word)
                OPC_OR_MEM:  acc_r <= acc_r | mem_rd_data;
                OPC_ROT_R: begin
                    acc_r        <= {carry_flag_r, acc_r[3:1]};
                    carry_flag_r <= acc_r[0];
                end
                OPC_CY_CLR:  carry_flag_r <= 1'b0;
                OPC_HBR_RST: high_bit_ref_enable_flag_r <= 1'b0;
                default: ;
            endcase
        end
    end

    // Power-off arming: only the instruction right after enable counts
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pof_armed_r <= 1'b0;
            backup_r    <= 1'b0;
        end else if (go) begin
            pof_armed_r <= !skip_r && (instr_word == OPC_POF_EN);
            if (!skip_r && instr_word == OPC_POF && pof_armed_r) begin
                backup_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Ports and memory write
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port0_r <= NIB_ZERO;
            port1_r <= NIB_ZERO;
            port2_r <= 2'h0;
            portd_r <= PD_RST;
        end else if (go && !skip_r) begin
            case (instr_word)
                OPC_PORT0:  port0_r <= acc_r;
                OPC_PORT1:  port1_r <= acc_r;
                OPC_PORT2:  port2_r <= acc_r[1:0];
                OPC_PD_CLR: portd_r[y_r[1:0]] <= 1'b0;
                default: ;
            endcase
        end
    end

    // Bit clear is a read-modify-write of the addressed nibble
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_en   <= 1'b0;
            mem_wr_data <= NIB_ZERO;
        end else begin
            mem_wr_en   <= go && !skip_r && is_bclr;
            mem_wr_data <= mem_rd_data & ~(4'h1 << instr_word[1:0]);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ret_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        run && is_ret |=> busy_r ##1 !busy_r)
        else $error("return not two cycles");
    rts_skip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        run && is_rts && !push_en |=> ##1 skip_r)
        else $error("skip not set after return-and-skip");
    lxy_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && lxy_skip |=> $stable(x_r) && $stable(y_r))
        else $error("second pointer load executed");
    rot_ring_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && !skip_r && instr_word == OPC_ROT_R
        |=> carry_flag_r == $past(acc_r[0]) && acc_r[3] == $past(carry_flag_r))
        else $error("rotate ring wrong");
    or_mem_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && !skip_r && instr_word == OPC_OR_MEM
        |=> acc_r == ($past(acc_r) | $past(mem_rd_data)) && $stable(carry_flag_r))
        else $error("or result wrong");
    pof_bare_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && !pof_armed_r && !backup_r |=> !backup_r)
        else $error("power off without enable");
    port2_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && !skip_r && instr_word == OPC_PORT2 |=> port2_r == $past(acc_r[1:0]))
        else $error("port 2 write wrong");
    nop_pc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && instr_word == OPC_NOP && !push_en
        |=> pc_r == $past(pc_r) + PC_ONE && $stable(acc_r))
        else $error("nop changed state");
endmodule

// *** test/prog_mem_model.sv ***
// Program memory and data nibble model facing the instruction executor
// Assumes the bench queues words and presets the nibble at the data pointer
`timescale 1ns/1ns
module prog_mem_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Bench side
    input  wire logic       req_valid,
    input  wire logic [9:0] req_word,
    input  wire logic       preset_en,
    input  wire logic [3:0] preset_data,
    // Executor side
    input  wire logic       mem_wr_en,
    input  wire logic [3:0] mem_wr_data,
    output logic            instr_valid,
    output logic [9:0]      instr_word,
    output logic [3:0]      mem_rd_data
);
    logic [9:0] last_r;
    logic [3:0] mem_r;
    // Idle bus shows the inverse of the last word so stale data never matches
    assign instr_valid = req_valid;
    assign instr_word  = req_valid ? req_word : ~last_r;
    assign mem_rd_data = mem_r;
    // ----------------------------------------
    // Last word and nibble at the data pointer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 10'h000;
            mem_r  <= 4'h0;
        end else begin
            if (req_valid) last_r <= req_word;
            if (mem_wr_en) mem_r <= mem_wr_data;
            else if (preset_en) mem_r <= preset_data;
        end
    end
endmodule

// *** test/tb_instr_subset_exec.sv ***
// Self-checking bench for the instruction subset executor
// Assumes program memory model in prog_mem_model, one clock at 125 MHz
`timescale 1ns/1ns
module tb_instr_subset_exec;
    import instr_subset_pkg::*;
    typedef struct packed {logic [9:0] w; logic [3:0] m; int s; logic [12:0] e;} row_t;
    logic sys_clk, rst_n, req_valid, preset_en, mem_wr_en, instr_valid, push_en;
    logic [9:0] req_word, instr_word;
    logic [3:0] preset_data, mem_wr_data, mem_rd_data, save_x, save_y, save_b;
    logic [1:0] save_z, port2_r, z_r;
    logic save_carry, save_skip, save_nop_mode, save_cont_load, carry_flag_r;
    logic skip_r, nop_mode_r, hbr_r, busy_r, backup_r;
    logic [PC_W-1:0] push_pc, pc_r;
    logic [SP_W-1:0] sp_r;
    logic [3:0] acc_r, x_r, y_r, b_r, port0_r, port1_r, portd_r;
    int n_errors = 0;
    int tests_run = 0;
    row_t rows [14];
    prog_mem_model u_prog_mem_model (.sys_clk(sys_clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_word(req_word), .preset_en(preset_en),
        .preset_data(preset_data), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
        .instr_valid(instr_valid), .instr_word(instr_word), .mem_rd_data(mem_rd_data));
    instr_subset_exec u_instr_subset_exec (.sys_clk(sys_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word), .mem_rd_data(mem_rd_data),
        .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .save_x(save_x),
        .save_y(save_y), .save_z(save_z), .save_carry(save_carry), .save_skip(save_skip),
        .save_nop_mode(save_nop_mode), .save_cont_load(save_cont_load), .save_b(save_b),
        .push_en(push_en), .push_pc(push_pc), .pc_r(pc_r), .stack_pointer_r(sp_r),
        .acc_r(acc_r), .carry_flag_r(carry_flag_r), .x_r(x_r), .y_r(y_r), .z_r(z_r),
        .b_r(b_r), .skip_r(skip_r), .nop_mode_r(nop_mode_r),
        .high_bit_ref_enable_flag_r(hbr_r), .busy_r(busy_r), .port0_r(port0_r),
        .port1_r(port1_r), .port2_r(port2_r), .portd_r(portd_r), .backup_r(backup_r));
    // Clock, 8 ns period
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // -------------------------------
    // Tasks
    // -------------------------------
    task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Chain keeps valid high so the next word is back to back
    task automatic exec(input logic [9:0] w, input bit chain);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_word  <= w;
        if (!chain) begin
            @(posedge sys_clk);
            req_valid <= 1'b0;
            #1;
        end
    endtask
    task automatic set_mem(input logic [3:0] m);
        @(posedge sys_clk);
        preset_en   <= 1'b1;
        preset_data <= m;
        @(posedge sys_clk);
        preset_en <= 1'b0;
    endtask
    task automatic push(input logic [PC_W-1:0] v);
        @(posedge sys_clk);
        push_en <= 1'b1;
        push_pc <= v;
        @(posedge sys_clk);
        push_en <= 1'b0;
    endtask
    // Bounded wait for the return's second cycle to finish
    task automatic wait_idle();
        int k;
        for (k = 0; k < 10 && busy_r !== 1'b0; k++) @(posedge sys_clk);
        #1;
        if (busy_r !== 1'b0) begin
            n_errors++;
            $display("Error busy_r expected %h seen %h", 1'b0, busy_r);
            final_report();
        end
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
    endtask
    function automatic logic [12:0] obs(input int s);
        case (s)
            0: obs = {9'h000, acc_r};
            1: obs = {12'h000, carry_flag_r};
            2: obs = {9'h000, x_r};
            3: obs = {9'h000, y_r};
            4: obs = {11'h000, z_r};
            5: obs = {9'h000, port0_r};
            6: obs = {9'h000, port1_r};
            7: obs = {11'h000, port2_r};
            8: obs = {9'h000, portd_r};
            9: obs = {9'h000, mem_rd_data};
            10: obs = {12'h000, hbr_r};
            default: obs = pc_r;
        endcase
    endfunction
    // -------------------------------
    // Main sequence
    // -------------------------------
    initial begin
        rst_n = 1'b0; req_valid = 1'b0; req_word = 10'h000; preset_en = 1'b0;
        preset_data = 4'h0; push_en = 1'b0; push_pc = 13'h0000; save_x = 4'h9;
        save_y = 4'h1; save_z = 2'h2; save_carry = 1'b1; save_skip = 1'b0;
        save_nop_mode = 1'b1; save_cont_load = 1'b0; save_b = 4'h6;
        rows = '{'{OPC_OR_MEM, 4'ha, 0, 13'h00a}, '{OPC_PORT0, 4'h0, 5, 13'h00a},
            '{OPC_PORT1, 4'h0, 6, 13'h00a}, '{OPC_PORT2, 4'h0, 7, 13'h002},
            '{OPC_ROT_R, 4'h0, 0, 13'h005}, '{OPC_ROT_R, 4'h0, 1, 13'h001},
            '{OPC_CY_CLR, 4'h0, 1, 13'h000}, '{10'h332, 4'h0, 2, 13'h003},
            '{OPC_NOP, 4'h0, 3, 13'h002}, '{OPC_NOP, 4'h0, 11, 13'h00a},
            '{10'h04b, 4'h0, 4, 13'h003}, '{OPC_PD_CLR, 4'h0, 8, 13'h00b},
            '{10'h04d, 4'hf, 9, 13'h00d}, '{OPC_HBR_RST, 4'h0, 10, 13'h000}};
        do_reset();
        foreach (rows[i]) begin
            set_mem(rows[i].m);
            exec(rows[i].w, 1'b0);
            @(posedge sys_clk);
            #1;
            check("row", obs(rows[i].s), rows[i].e);
        end
        $display("Table done");
        exec(10'h356, 1'b1);
        exec(10'h378, 1'b0);
        check("x_r", {9'h000, x_r}, 13'h005);
        check("y_r", {9'h000, y_r}, 13'h006);
        $display("Pointer run done");
        push(13'h0abc);
        exec(OPC_SUB_RET, 1'b0);
        check("pc_r", pc_r, 13'h0abc);
        check("sp_r", {10'h000, sp_r}, {10'h000, SP_RST});
        check("busy_r", {12'h000, busy_r}, 13'h001);
        wait_idle();
        push(13'h0123);
        exec(OPC_SKIP_RET, 1'b0);
        wait_idle();
        set_mem(4'hf);
        exec(OPC_OR_MEM, 1'b0);
        check("acc skipped", {9'h000, acc_r}, 13'h002);
        set_mem(4'h1);
        exec(OPC_OR_MEM, 1'b0);
        check("acc after", {9'h000, acc_r}, 13'h003);
        $display("Returns done");
        push(13'h0055);
        exec(OPC_INT_RET, 1'b0);
        wait_idle();
        check("rti pc", pc_r, 13'h0055);
        check("rti xyz", {3'h0, x_r, y_r, z_r}, 13'h0246);
        check("rti cy b", {8'h00, carry_flag_r, b_r}, 13'h0016);
        check("rti nop mode", {12'h000, nop_mode_r}, 13'h001);
        $display("Interrupt return done");
        exec(OPC_POF, 1'b0);
        check("pof alone", {12'h000, backup_r}, 13'h000);
        exec(OPC_POF_EN, 1'b1);
        exec(OPC_POF, 1'b0);
        check("pof armed", {12'h000, backup_r}, 13'h001);
        $display("Power off done");
        do_reset();
        check("rst portd", {9'h000, portd_r}, {9'h000, PD_RST});
        check("rst pc sp", {pc_r[9:0], sp_r}, {10'h000, SP_RST});
        check("rst backup", {12'h000, backup_r}, 13'h000);
        $display("Reset done");
        final_report();
    end
endmodule
